// ### rtl/pim_pkg.sv
package pim_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PIM_SLOTS = 8;
    localparam int PIM_PINS = 48;
    localparam int PIM_SELW = 6;
    localparam int PIM_CNDW = 3;
    localparam int PIM_AW = 12;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [PIM_AW-1:0] PIM_OFF_MODE = 12'h000;
    localparam logic [PIM_AW-1:0] PIM_OFF_RISE = 12'h004;
    localparam logic [PIM_AW-1:0] PIM_OFF_FALL = 12'h008;
    localparam logic [PIM_AW-1:0] PIM_OFF_SEL0 = 12'h00C;
    localparam logic [PIM_AW-1:0] PIM_OFF_SEL1 = 12'h010;
    localparam logic [PIM_AW-1:0] PIM_OFF_CTRL = 12'h014;
    localparam logic [PIM_AW-1:0] PIM_OFF_SRC = 12'h018;
    localparam logic [PIM_AW-1:0] PIM_OFF_CFG = 12'h01C;
    localparam logic [PIM_AW-1:0] PIM_OFF_STAT = 12'h020;
    localparam logic [PIM_AW-1:0] PIM_OFF_CLR = 12'h024;
    localparam logic [PIM_AW-1:0] PIM_OFF_ENA = 12'h028;
    localparam logic [PIM_AW-1:0] PIM_OFF_LVL = 12'h02C;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int PIM_CTRL_PM_BIT = 0;
    localparam int PIM_CTRL_EV_BIT = 1;
    localparam int PIM_CTRL_END_LSB = 8;
    localparam logic [7:0] PIM_RST_BYTE = 8'h00;
    localparam logic [PIM_SELW-1:0] PIM_RST_SEL = 6'h00;
    localparam logic [PIM_CNDW-1:0] PIM_RST_CND = 3'h0;

    // ------------------------------------------------------------
    // slice conditions
    // ------------------------------------------------------------
    localparam logic [PIM_CNDW-1:0] PIM_CND_ONE = 3'h0;
    localparam logic [PIM_CNDW-1:0] PIM_CND_RISE = 3'h1;
    localparam logic [PIM_CNDW-1:0] PIM_CND_FALL = 3'h2;
    localparam logic [PIM_CNDW-1:0] PIM_CND_EDGE = 3'h3;
    localparam logic [PIM_CNDW-1:0] PIM_CND_HIGH = 3'h4;
    localparam logic [PIM_CNDW-1:0] PIM_CND_LOW = 3'h5;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] PIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIM_RESP_SLVERR = 2'h2;
endpackage

// ### rtl/pim_pin_sync.sv
module pim_pin_sync
    import pim_pkg::*;
#(
    parameter int WIDTH = PIM_PINS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] lvl,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } pim_sync_t;

    pim_sync_t r;
    pim_sync_t n;

    // two stages, then a history stage for edges
    always_comb begin
        n.s1 = pin_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // edges compare current and previous synced samples
    assign lvl = r.s2;
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule

// ### rtl/pim_top.sv
// Function
// - up to eight slots, each picking any port 0 or port 1 pin, act as edge or level request sources.
// - every slot drives its own interrupt line to the processor interrupt controller.
// - an edge slot requests on rising, falling or both edges of its pin.
// - a level slot requests while its pin is high, or while it is low.
// - pin interrupts keep working and raise wake in sleep and deep-sleep.
// - the pattern engine takes up to eight selected pins as inputs to one expression.
// - each slice tests one pin for a level or a transition, except a constant-true slice, which tests no pin.
// - every product term raises its own interrupt when it is satisfied.
// - when enabled, a match gives a one-cycle core event pulse, also brought out to a pin.
// - the pattern engine works only in active and sleep, not in deep-sleep.
// - pin selection is made in the configuration block whatever function owns the pin.
// - registers answer each read or write within a single cycle.
module pim_top
    import pim_pkg::*;
#(
    parameter int SLOTS = PIM_SLOTS,
    parameter int PINS = PIM_PINS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [PINS-1:0] gpio_pins,
    input wire logic deep_sleep,
    input wire logic [PIM_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PIM_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [SLOTS-1:0] pin_irq,
    output logic irq,
    output logic wake_req,
    output logic core_event_pulse,
    output logic core_event_pin
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (SLOTS != PIM_SLOTS || PINS > (1 << PIM_SELW) || PINS < 1) begin : g_chk
        $error("pim_top: unsupported SLOTS or PINS");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] rise_en;
        logic [7:0] fall_en;
        logic [7:0][PIM_SELW-1:0] sel;
        logic pm_en;
        logic ev_en;
        logic [7:0] endpt;
        logic [7:0][PIM_CNDW-1:0] src;
        logic [7:0][PIM_CNDW-1:0] cfg;
        logic [7:0] status;
        logic [7:0] enable;
        logic [7:0] match_q;
        logic ev;
        logic aw_ok;
        logic [PIM_AW-1:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pim_state_t;

    pim_state_t r;
    pim_state_t n;

    logic [PINS-1:0] p_lvl;
    logic [PINS-1:0] p_rise;
    logic [PINS-1:0] p_fall;
    logic [7:0] s_lvl;
    logic [7:0] s_rise;
    logic [7:0] s_fall;
    logic [7:0] pin_ev;
    logic [7:0] slc;
    logic [7:0] match;
    logic [7:0] set;
    logic [7:0] clr;
    logic acc;
    logic do_wr;
    logic [PIM_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] rd;
    logic rd_hit;
    logic wr_hit;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pim_pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(gpio_pins),
        .lvl(p_lvl),
        .rise(p_rise),
        .fall(p_fall)
    );

    // merges bytes of a write into an old word
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    // ------------------------------------------------------------
    // slot selection and per slot events
    // ------------------------------------------------------------
    for (genvar k = 0; k < 8; k++) begin : g_slot
        logic ok;
        assign ok = {1'b0, r.sel[k]} < (PIM_SELW+1)'(PINS);
        // any pin, whatever its function, may be picked
        assign s_lvl[k] = ok & p_lvl[r.sel[k]];
        assign s_rise[k] = ok & p_rise[r.sel[k]];
        assign s_fall[k] = ok & p_fall[r.sel[k]];
        // edge mode uses rise and fall enables, level mode uses enable and polarity
        assign pin_ev[k] = r.mode[k]
            ? (r.rise_en[k] & (r.fall_en[k] ? s_lvl[k] : ~s_lvl[k]))
            : ((r.rise_en[k] & s_rise[k]) | (r.fall_en[k] & s_fall[k]));
        // slice test on its chosen slot input
        always_comb begin
            case (r.cfg[k])
                PIM_CND_ONE: slc[k] = 1'b1;
                PIM_CND_RISE: slc[k] = s_rise[r.src[k]];
                PIM_CND_FALL: slc[k] = s_fall[r.src[k]];
                PIM_CND_EDGE: slc[k] = s_rise[r.src[k]] | s_fall[r.src[k]];
                PIM_CND_HIGH: slc[k] = s_lvl[r.src[k]];
                PIM_CND_LOW: slc[k] = ~s_lvl[r.src[k]];
                default: slc[k] = 1'b0;
            endcase
        end
    end

    // product terms end at every slice marked as an endpoint
    always_comb begin
        acc = 1'b1;
        match = '0;
        for (int i = 0; i < 8; i++) begin
            acc = acc & slc[i];
            match[i] = r.endpt[i] & acc;
            if (r.endpt[i]) begin
                acc = 1'b1;
            end
        end
    end

    // pattern engine is held off in deep-sleep
    assign set = r.pm_en ? (deep_sleep ? 8'h00 : match) : pin_ev;

    // ------------------------------------------------------------
    // bus write path
    // ------------------------------------------------------------
    assign s_axi_awready = !r.aw_ok && !r.bvalid;
    assign s_axi_wready = !r.w_ok && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign wa = r.aw_ok ? r.awaddr : s_axi_awaddr;
    assign wd = r.w_ok ? r.wdata : s_axi_wdata;
    assign ws = r.w_ok ? r.wstrb : s_axi_wstrb;
    assign do_wr = (r.aw_ok || (s_axi_awvalid && s_axi_awready))
        && (r.w_ok || (s_axi_wvalid && s_axi_wready)) && !r.bvalid;
    assign clr = (do_wr && wa == PIM_OFF_CLR) ? (wd[7:0] & {8{ws[0]}}) : 8'h00;

    // read mux of register words
    always_comb begin
        rd = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            PIM_OFF_MODE: rd[7:0] = r.mode;
            PIM_OFF_RISE: rd[7:0] = r.rise_en;
            PIM_OFF_FALL: rd[7:0] = r.fall_en;
            PIM_OFF_SEL0: for (int k = 0; k < 4; k++) rd[8*k +: PIM_SELW] = r.sel[k];
            PIM_OFF_SEL1: for (int k = 0; k < 4; k++) rd[8*k +: PIM_SELW] = r.sel[k+4];
            PIM_OFF_CTRL: begin
                rd[PIM_CTRL_PM_BIT] = r.pm_en;
                rd[PIM_CTRL_EV_BIT] = r.ev_en;
                rd[PIM_CTRL_END_LSB +: 8] = r.endpt;
            end
            PIM_OFF_SRC: rd[23:0] = r.src;
            PIM_OFF_CFG: rd[23:0] = r.cfg;
            PIM_OFF_STAT: rd[7:0] = r.status;
            PIM_OFF_CLR: rd = '0;
            PIM_OFF_ENA: rd[7:0] = r.enable;
            PIM_OFF_LVL: rd[7:0] = s_lvl;
            default: rd_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] v;
        v = '0;
        n = r;
        wr_hit = 1'b1;
        // address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_ok = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_ok = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            case (wa)
                PIM_OFF_MODE: begin
                    v = wmerge({24'h00_0000, r.mode}, wd, ws);
                    n.mode = v[7:0];
                end
                PIM_OFF_RISE: begin
                    v = wmerge({24'h00_0000, r.rise_en}, wd, ws);
                    n.rise_en = v[7:0];
                end
                PIM_OFF_FALL: begin
                    v = wmerge({24'h00_0000, r.fall_en}, wd, ws);
                    n.fall_en = v[7:0];
                end
                PIM_OFF_SEL0, PIM_OFF_SEL1: begin
                    for (int k = 0; k < 4; k++) begin
                        if (ws[k] && wa == PIM_OFF_SEL0) n.sel[k] = wd[8*k +: PIM_SELW];
                        if (ws[k] && wa == PIM_OFF_SEL1) n.sel[k+4] = wd[8*k +: PIM_SELW];
                    end
                end
                PIM_OFF_CTRL: begin
                    v = wmerge({16'h0000, r.endpt, 6'h00, r.ev_en, r.pm_en}, wd, ws);
                    n.pm_en = v[PIM_CTRL_PM_BIT];
                    n.ev_en = v[PIM_CTRL_EV_BIT];
                    n.endpt = v[PIM_CTRL_END_LSB +: 8];
                end
                PIM_OFF_SRC: begin
                    v = wmerge({8'h00, r.src}, wd, ws);
                    n.src = v[23:0];
                end
                PIM_OFF_CFG: begin
                    v = wmerge({8'h00, r.cfg}, wd, ws);
                    n.cfg = v[23:0];
                end
                PIM_OFF_ENA: begin
                    v = wmerge({24'h00_0000, r.enable}, wd, ws);
                    n.enable = v[7:0];
                end
                PIM_OFF_STAT, PIM_OFF_CLR, PIM_OFF_LVL: v = '0;
                default: wr_hit = 1'b0;
            endcase
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_hit ? PIM_RESP_OKAY : PIM_RESP_SLVERR;
        end else if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        // reads answer on the next edge
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd;
            n.rresp = rd_hit ? PIM_RESP_OKAY : PIM_RESP_SLVERR;
        end else if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        // sticky status, a new event wins over a clear
        n.status = (r.status & ~clr) | set;
        // one pulse per new match
        n.match_q = set & {8{r.pm_en}};
        n.ev = r.ev_en && r.pm_en && !deep_sleep && |(match & ~r.match_q);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign pin_irq = r.status & r.enable;
    assign irq = |pin_irq;
    assign wake_req = |pin_irq && !(r.pm_en && deep_sleep);
    assign core_event_pulse = r.ev;
    assign core_event_pin = r.ev;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_edge_rise;
        @(posedge ref_clk) disable iff (rst)
        !r.pm_en && !r.mode[0] && r.rise_en[0] && s_rise[0] |=> r.status[0];
    endproperty
    a_edge_rise: assert property (p_edge_rise) else $error("rise edge not flagged");

    property p_edge_fall_off;
        @(posedge ref_clk) disable iff (rst)
        !r.pm_en && !r.mode[1] && !r.rise_en[1] && !r.fall_en[1] && !r.status[1]
            |=> !r.status[1];
    endproperty
    a_edge_fall_off: assert property (p_edge_fall_off) else $error("disabled slot flagged");

    property p_level_low;
        @(posedge ref_clk) disable iff (rst)
        !r.pm_en && r.mode[1] && r.rise_en[1] && !r.fall_en[1] && !s_lvl[1] |=> r.status[1];
    endproperty
    a_level_low: assert property (p_level_low) else $error("low level not flagged");

    property p_own_line;
        @(posedge ref_clk) disable iff (rst)
        r.enable[3] && $rose(r.status[3]) |-> pin_irq[3] && irq;
    endproperty
    a_own_line: assert property (p_own_line) else $error("slot line not raised");

    property p_ev_pulse;
        @(posedge ref_clk) disable iff (rst)
        core_event_pulse |=> !core_event_pulse || $changed(match);
    endproperty
    a_ev_pulse: assert property (p_ev_pulse) else $error("event pulse too long");

    property p_no_pm_deep;
        @(posedge ref_clk) disable iff (rst)
        deep_sleep && r.pm_en ##1 deep_sleep |-> !core_event_pulse && !wake_req;
    endproperty
    a_no_pm_deep: assert property (p_no_pm_deep) else $error("pattern active in deep-sleep");

    property p_deep_wake;
        @(posedge ref_clk) disable iff (rst)
        !r.pm_en && r.enable[0] && r.status[0] |-> wake_req;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("no wake from pin irq");

    property p_rd_one;
        @(posedge ref_clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_one: assert property (p_rd_one) else $error("read not answered in one cycle");

    property p_wr_one;
        @(posedge ref_clk) disable iff (rst)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_wr_one: assert property (p_wr_one) else $error("write not answered in one cycle");

    property p_sync;
        @(posedge ref_clk) disable iff (rst)
        ##3 1'b1 |-> p_lvl[0] == $past(gpio_pins[0], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin sync delay wrong");

    c_edge_irq: cover property (@(posedge ref_clk) disable iff (rst) $rose(pin_irq[0]));
    c_match: cover property (@(posedge ref_clk) disable iff (rst) core_event_pulse);
    c_deep_wake: cover property (@(posedge ref_clk) disable iff (rst) deep_sleep && wake_req);
endmodule

// ### verification/pim_pin_model.sv
module pim_pin_model
    import pim_pkg::*;
#(
    parameter int PINS = PIM_PINS
) (
    input wire logic ref_clk,
    output logic [PINS-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // external pin levels
    // ------------------------------------------------------------
    // all pins idle low until a scenario moves one
    initial begin
        pins = '0;
    end

    // one pin changes just after a rising edge and then holds
    task automatic set_pin(input int idx, input logic v);
        @(posedge ref_clk);
        pins[idx] <= v;
    endtask
endmodule

// ### verification/pim_top_tb.sv
module pim_top_tb
    import pim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic deep_sleep = 1'b0;
    logic [PIM_PINS-1:0] gpio_pins;
    logic [PIM_AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [PIM_SLOTS-1:0] pin_irq;
    logic irq, wake_req, core_event_pulse, core_event_pin;
    int mismatches = 0, tests_run = 0, cycles = 0, ev_cycles = 0, ev_pin_cycles = 0;

    // ------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    pim_pin_model #(.PINS(PIM_PINS)) pim_pin_model_i (.ref_clk(ref_clk), .pins(gpio_pins));

    pim_top #(.SLOTS(PIM_SLOTS), .PINS(PIM_PINS)) pim_top_i (
        .ref_clk(ref_clk), .rst(rst), .gpio_pins(gpio_pins), .deep_sleep(deep_sleep),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_irq(pin_irq), .irq(irq), .wake_req(wake_req),
        .core_event_pulse(core_event_pulse), .core_event_pin(core_event_pin));

    // counts event cycles on both outputs and cuts a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (core_event_pulse === 1'b1) ev_cycles <= ev_cycles + 1;
        if (core_event_pin === 1'b1) ev_pin_cycles <= ev_pin_cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // write: address and data offered together, each released when taken
    task automatic axi_write(input logic [PIM_AW-1:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [PIM_AW-1:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [PIM_AW-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, PIM_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [PIM_AW-1:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(what, d, exp);
        check("rresp", {30'h0, r}, {30'h0, PIM_RESP_OKAY});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_and_map();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(PIM_OFF_CTRL, 32'h0000_0000, "ctrl reset");
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "status reset");
        rd_chk(PIM_OFF_SEL0, 32'h0000_0000, "sel0 reset");
        axi_read(12'h100, d, r);
        check("unmapped rresp", {30'h0, r}, {30'h0, PIM_RESP_SLVERR});
        check("unmapped rdata", d, 32'h0000_0000);
        axi_write(12'h100, 32'h0000_00ff, r);
        check("unmapped bresp", {30'h0, r}, {30'h0, PIM_RESP_SLVERR});
    endtask

    task automatic edge_modes();
        logic rs, fl;
        wr(PIM_OFF_SEL0, 32'h0000_0005);
        wr(PIM_OFF_ENA, 32'h0000_0001);
        for (int m = 0; m < 3; m++) begin
            rs = (m != 1);
            fl = (m != 0);
            wr(PIM_OFF_RISE, {31'h0, rs});
            wr(PIM_OFF_FALL, {31'h0, fl});
            wr(PIM_OFF_CLR, 32'h0000_00ff);
            pim_pin_model_i.set_pin(5, 1'b1);
            wait_cyc(5);
            rd_chk(PIM_OFF_STAT, {31'h0, rs}, "status after rise");
            check("pin_irq rise", {24'h0, pin_irq}, {31'h0, rs});
            check("irq rise", {31'h0, irq}, {31'h0, rs});
            wr(PIM_OFF_ENA, 32'h0000_0000);
            check("irq masked", {31'h0, irq}, 32'h0000_0000);
            wr(PIM_OFF_ENA, 32'h0000_0001);
            wr(PIM_OFF_CLR, 32'h0000_00ff);
            pim_pin_model_i.set_pin(5, 1'b0);
            wait_cyc(5);
            rd_chk(PIM_OFF_STAT, {31'h0, fl}, "status after fall");
        end
        rd_chk(PIM_OFF_CLR, 32'h0000_0000, "clear reads zero");
    endtask

    task automatic level_modes();
        wr(PIM_OFF_SEL0, 32'h0000_2805);
        wr(PIM_OFF_MODE, 32'h0000_0002);
        wr(PIM_OFF_RISE, 32'h0000_0002);
        wr(PIM_OFF_FALL, 32'h0000_0002);
        wr(PIM_OFF_ENA, 32'h0000_0002);
        wr(PIM_OFF_CLR, 32'h0000_00ff);
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "high level idle");
        pim_pin_model_i.set_pin(40, 1'b1);
        wait_cyc(5);
        rd_chk(PIM_OFF_LVL, 32'h0000_0002, "slot levels");
        wr(PIM_OFF_CLR, 32'h0000_0002);
        wait_cyc(2);
        rd_chk(PIM_OFF_STAT, 32'h0000_0002, "high level holds");
        check("pin_irq level", {24'h0, pin_irq}, 32'h0000_0002);
        wr(PIM_OFF_FALL, 32'h0000_0000);
        wr(PIM_OFF_CLR, 32'h0000_0002);
        wait_cyc(2);
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "low level inactive");
        pim_pin_model_i.set_pin(40, 1'b0);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0002, "low level active");
        pim_pin_model_i.set_pin(40, 1'b1);
        wait_cyc(5);
        wr(PIM_OFF_CLR, 32'h0000_0002);
        wait_cyc(2);
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "low level cleared");
    endtask

    task automatic pattern_and_sleep();
        pim_pin_model_i.set_pin(40, 1'b0);
        wr(PIM_OFF_SEL0, 32'h002f_2805);
        wr(PIM_OFF_SRC, 32'h0000_0088);
        wr(PIM_OFF_CFG, 32'h0000_008c);
        wr(PIM_OFF_ENA, 32'h0000_0006);
        wr(PIM_OFF_CTRL, 32'h0000_0603);
        wait_cyc(5);
        wr(PIM_OFF_CLR, 32'h0000_00ff);
        pim_pin_model_i.set_pin(40, 1'b1);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "term needs both");
        pim_pin_model_i.set_pin(40, 1'b0);
        pim_pin_model_i.set_pin(5, 1'b1);
        wait_cyc(5);
        pim_pin_model_i.set_pin(40, 1'b1);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0002, "first term");
        check("term irq", {24'h0, pin_irq}, 32'h0000_0002);
        check("event once", ev_cycles, 32'h0000_0001);
        check("event pin", ev_pin_cycles, 32'h0000_0001);
        pim_pin_model_i.set_pin(47, 1'b1);
        wait_cyc(5);
        wr(PIM_OFF_CLR, 32'h0000_00ff);
        pim_pin_model_i.set_pin(47, 1'b0);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0004, "second term");
        check("event twice", ev_cycles, 32'h0000_0002);
        pim_pin_model_i.set_pin(40, 1'b0);
        wait_cyc(5);
        wr(PIM_OFF_CLR, 32'h0000_00ff);
        @(posedge ref_clk);
        deep_sleep <= 1'b1;
        pim_pin_model_i.set_pin(40, 1'b1);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0000, "pattern asleep");
        check("no wake", {31'h0, wake_req}, 32'h0000_0000);
        check("no event asleep", ev_cycles, 32'h0000_0002);
        wr(PIM_OFF_CTRL, 32'h0000_0000);
        wr(PIM_OFF_MODE, 32'h0000_0000);
        wr(PIM_OFF_RISE, 32'h0000_0001);
        wr(PIM_OFF_ENA, 32'h0000_0001);
        pim_pin_model_i.set_pin(5, 1'b0);
        wait_cyc(5);
        wr(PIM_OFF_CLR, 32'h0000_00ff);
        pim_pin_model_i.set_pin(5, 1'b1);
        wait_cyc(5);
        rd_chk(PIM_OFF_STAT, 32'h0000_0001, "pin irq asleep");
        check("wake asleep", {31'h0, wake_req}, 32'h0000_0001);
        @(posedge ref_clk);
        deep_sleep <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        wait_cyc(4);
        reset_and_map();
        edge_modes();
        level_modes();
        pattern_and_sleep();
        conclude();
    end
endmodule
